// file: shared/sbp_pkg.sv
// constants, field positions and carrier types of the serial burst block
// assumes the importer works with 16-bit words and 6-bit locations
package sbp_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LEN_W = 7;
  localparam int unsigned BUF_DEPTH = 64;
  // location map
  localparam logic [5:0] LOC_RX_BUF = 6'h01;
  localparam logic [5:0] LOC_TX_BUF = 6'h02;
  localparam logic [5:0] LOC_TX_CTL = 6'h03;
  localparam logic [5:0] LOC_IRQ_MASK = 6'h05;
  localparam logic [5:0] LOC_IRQ_STAT = 6'h18;
  localparam logic [5:0] LOC_RX_COUNT = 6'h2d;
  localparam logic [5:0] LOC_LAST = 6'h3f;
  localparam logic [5:0] LOC_WRAP = 6'h03;
  // field positions
  localparam int unsigned TX_CHOICE_BIT = 15;
  localparam int unsigned OVR_FLAG_BIT = 14;
  localparam int unsigned CONT_FLAG_BIT = 13;
  localparam int unsigned OVR_EN_BIT = 12;
  localparam int unsigned CONT_EN_BIT = 11;
  // framing counts
  localparam logic [3:0] HDR_LAST_BIT = 4'h7;
  localparam logic [3:0] WORD_LAST_BIT = 4'hf;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [6:0] PTR_STEP = 7'h01;
  localparam logic [6:0] CRC_BYTES = 7'h02;
  localparam logic [6:0] CRC_LAST_OFS = 7'h01;
  // reset and fill values
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] DUMMY_WORD = 16'h0000;
  localparam logic [15:0] OVR_FILL = 16'h0000;
  localparam logic [6:0] LEN_RESET = 7'h00;

  typedef struct packed {
    logic rd;
    logic spare;
    logic [5:0] loc;
  } sbp_hdr_t;

  typedef struct packed {
    logic choice;
    logic [LEN_W-1:0] len;
  } sbp_txctl_t;

  typedef enum logic [2:0] {
    ST_HDR = 3'b001,
    ST_REG = 3'b010,
    ST_BUF = 3'b100
  } sbp_state_t;

  typedef enum logic [1:0] {
    BUF_RX = 2'h0,
    BUF_TX1 = 2'h1,
    BUF_TX2 = 2'h2
  } sbp_buf_t;
endpackage : sbp_pkg

// file: hw/sbp_spi_burst.sv
// serial slave with burst register access and three packet buffers
// assumes the host is a mode-0 serial master that frames with cs_n
`timescale 1ns/1ns
module sbp_spi_burst
  import sbp_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic eng_rx_busy,
  input wire logic eng_tx_busy,
  input wire logic [LEN_W-1:0] rx_count_in,
  input wire logic rx_count_load,
  output logic irq,
  output logic tx_buffer_choice
);

  // link-domain frame state
  sbp_state_t st_reg, st_next;
  logic [3:0] bitc_reg, bitc_next;
  logic [14:0] sh_in_reg, sh_in_next;
  sbp_hdr_t hdr_reg, hdr_next;
  logic [5:0] ptr_reg, ptr_next;
  logic [6:0] bptr_reg, bptr_next;
  sbp_buf_t bsel_reg, bsel_next;
  logic [15:0] out_sh_reg, out_sh_next;
  logic ovr_pend_reg, ovr_pend_next;
  logic clr_pend_reg, clr_pend_next;
  logic buf_act_reg, buf_act_next;
  // link-domain storage
  sbp_txctl_t ctl_reg, ctl_next;
  logic [15:0] mask_reg, mask_next;
  logic ovr_reg, ovr_next;
  logic cont_reg, cont_next;
  logic [LEN_W-1:0] rcnt_reg, rcnt_next;
  logic irq_req_reg, irq_req_next;
  logic rs_s1_reg, rs_s2_reg;
  logic ct_s1_reg, ct_s2_reg, ct_s3_reg;
  logic cg_s1_reg, cg_s2_reg, cg_s3_reg;
  logic [15:0] rx_mem [0:BUF_DEPTH-1];
  logic [15:0] tx_mem [0:1][0:BUF_DEPTH-1];
  // strobes from frame logic
  logic set_ovr, clr_req, reg_we, mem_we;
  logic [5:0] reg_wa;
  logic [15:0] word_in;
  sbp_hdr_t hv;
  logic [5:0] nptr;
  // system-domain state
  logic act_s1_reg, act_s1_next, act_s2_reg, act_s2_next;
  logic cont_d_reg, cont_d_next, ct_tgl_reg, ct_tgl_next;
  logic [LEN_W-1:0] cnt_hold_reg, cnt_hold_next;
  logic cnt_tgl_reg, cnt_tgl_next;
  logic irq_s1_reg, irq_s1_next, irq_reg, irq_next;
  logic ch_s1_reg, ch_s1_next, ch_reg, ch_next;
  logic cont_cond;

  // next location, wrapping past the buffer windows
  function automatic logic [5:0] wrap_loc(input logic [5:0] p);
    wrap_loc = (p == LOC_LAST) ? LOC_WRAP : p + 6'h01;
  endfunction : wrap_loc

  // receive byte with the two checksum bytes swapped
  function automatic logic [7:0] rx_byte(input logic [6:0] j);
    logic [6:0] k;
    logic [15:0] w;
    k = j;
    if (rcnt_reg >= CRC_BYTES)
    begin
      if (j == rcnt_reg - CRC_BYTES)
        k = rcnt_reg - CRC_LAST_OFS;
      else if (j == rcnt_reg - CRC_LAST_OFS)
        k = rcnt_reg - CRC_BYTES;
    end
    w = rx_mem[k[6:1]];
    rx_byte = k[0] ? w[7:0] : w[15:8];
  endfunction : rx_byte

  // one buffer word as the host sees it
  function automatic logic [15:0] buf_word(input sbp_buf_t b,
                                           input logic [5:0] i);
    if (b == BUF_RX)
      buf_word = {rx_byte({i, 1'b0}), rx_byte({i, 1'b1})};
    else
      buf_word = tx_mem[b == BUF_TX2][i];
  endfunction : buf_word

  // readable locations
  function automatic logic [15:0] reg_read(input logic [5:0] a);
    reg_read = WORD_ZERO;
    case (a)
      LOC_TX_CTL:
      begin
        reg_read[TX_CHOICE_BIT] = ctl_reg.choice;
        reg_read[LEN_W-1:0] = ctl_reg.len;
      end
      LOC_IRQ_MASK: reg_read = mask_reg;
      LOC_IRQ_STAT:
      begin
        reg_read[OVR_FLAG_BIT] = ovr_reg;
        reg_read[CONT_FLAG_BIT] = cont_reg;
      end
      LOC_RX_COUNT: reg_read[LEN_W-1:0] = rcnt_reg;
      default: reg_read = WORD_ZERO;
    endcase
  endfunction : reg_read

  // frame decode, pointers and read loading
  always_comb
  begin
    st_next = st_reg;
    bitc_next = 4'(bitc_reg + BIT_STEP);
    sh_in_next = {sh_in_reg[13:0], mosi};
    hdr_next = hdr_reg;
    ptr_next = ptr_reg;
    bptr_next = bptr_reg;
    bsel_next = bsel_reg;
    out_sh_next = {out_sh_reg[14:0], 1'b0};
    ovr_pend_next = ovr_pend_reg;
    clr_pend_next = clr_pend_reg;
    buf_act_next = buf_act_reg;
    set_ovr = 1'b0;
    clr_req = 1'b0;
    reg_we = 1'b0;
    reg_wa = ptr_reg;
    mem_we = 1'b0;
    word_in = {sh_in_reg, mosi};
    hv = sbp_hdr_t'(word_in[7:0]);
    nptr = wrap_loc(ptr_reg);
    // side effects of a loaded word count once the host clocks it
    if (st_reg != ST_HDR && bitc_reg == BIT_FIRST)
    begin
      set_ovr = ovr_pend_reg;
      clr_req = clr_pend_reg;
      ovr_pend_next = 1'b0;
      clr_pend_next = 1'b0;
    end
    case (st_reg)
      ST_HDR:
      begin
        if (bitc_reg == HDR_LAST_BIT)
        begin
          hdr_next = hv;
          bitc_next = BIT_FIRST;
          ptr_next = hv.loc;
          bptr_next = 7'h00;
          if (hv.loc == LOC_RX_BUF || hv.loc == LOC_TX_BUF)
          begin
            st_next = ST_BUF;
            buf_act_next = 1'b1;
            if (hv.loc == LOC_RX_BUF)
              bsel_next = BUF_RX;
            else if (ctl_reg.choice)
              bsel_next = BUF_TX2;
            else
              bsel_next = BUF_TX1;
            if (hv.rd && hv.loc == LOC_RX_BUF)
              out_sh_next = DUMMY_WORD;
            else if (hv.rd)
            begin
              out_sh_next = buf_word(bsel_next, 6'h00);
              bptr_next = PTR_STEP;
            end
          end
          else
          begin
            st_next = ST_REG;
            if (hv.rd)
            begin
              out_sh_next = reg_read(hv.loc);
              clr_pend_next = (hv.loc == LOC_IRQ_STAT);
            end
          end
        end
      end
      ST_REG:
      begin
        if (bitc_reg == WORD_LAST_BIT)
        begin
          bitc_next = BIT_FIRST;
          ptr_next = nptr;
          if (hdr_reg.rd)
          begin
            out_sh_next = reg_read(nptr);
            clr_pend_next = (nptr == LOC_IRQ_STAT);
          end
          else
            reg_we = 1'b1;
        end
      end
      ST_BUF:
      begin
        if (bitc_reg == WORD_LAST_BIT)
        begin
          bitc_next = BIT_FIRST;
          if (bptr_reg[6])
          begin
            out_sh_next = OVR_FILL;
            ovr_pend_next = hdr_reg.rd;
            set_ovr = ~hdr_reg.rd;
          end
          else
          begin
            if (hdr_reg.rd)
              out_sh_next = buf_word(bsel_reg, bptr_reg[5:0]);
            else
              mem_we = 1'b1;
            bptr_next = 7'(bptr_reg + PTR_STEP);
          end
        end
      end
      default: st_next = ST_HDR;
    endcase
  end

  // frame registers, cleared whenever cs_n is high
  always_ff @(posedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      st_reg <= ST_HDR;
      bitc_reg <= BIT_FIRST;
      sh_in_reg <= 15'h0000;
      hdr_reg <= sbp_hdr_t'(8'h00);
      ptr_reg <= 6'h00;
      bptr_reg <= 7'h00;
      bsel_reg <= BUF_RX;
      out_sh_reg <= WORD_ZERO;
      ovr_pend_reg <= 1'b0;
      clr_pend_reg <= 1'b0;
      buf_act_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      bitc_reg <= bitc_next;
      sh_in_reg <= sh_in_next;
      hdr_reg <= hdr_next;
      ptr_reg <= ptr_next;
      bptr_reg <= bptr_next;
      bsel_reg <= bsel_next;
      out_sh_reg <= out_sh_next;
      ovr_pend_reg <= ovr_pend_next;
      clr_pend_reg <= clr_pend_next;
      buf_act_reg <= buf_act_next;
    end
  end

  // serial output changes on the falling edge, idle low when deselected
  always_ff @(negedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso <= out_sh_reg[15];
      miso_oe <= 1'b1;
    end
  end

  // packet buffer writes
  always_ff @(posedge spi_clk)
  begin
    if (mem_we && bsel_reg == BUF_RX)
      rx_mem[bptr_reg[5:0]] <= word_in;
    else if (mem_we)
      tx_mem[bsel_reg == BUF_TX2][bptr_reg[5:0]] <= word_in;
  end

  // location writes, flags and crossings into the link domain
  always_comb
  begin
    ctl_next = ctl_reg;
    mask_next = mask_reg;
    if (reg_we && reg_wa == LOC_TX_CTL)
    begin
      ctl_next.choice = word_in[TX_CHOICE_BIT];
      ctl_next.len = word_in[LEN_W-1:0];
    end
    if (reg_we && reg_wa == LOC_IRQ_MASK)
      mask_next = word_in;
    // set wins over a read-clear in the same edge
    ovr_next = set_ovr | (ovr_reg & ~clr_req);
    cont_next = (ct_s2_reg ^ ct_s3_reg) | (cont_reg & ~clr_req);
    rcnt_next = (cg_s2_reg ^ cg_s3_reg) ? cnt_hold_reg : rcnt_reg;
    irq_req_next = (ovr_reg & mask_reg[OVR_EN_BIT]) |
                   (cont_reg & mask_reg[CONT_EN_BIT]);
  end

  // link-domain storage with reset brought over from the system side
  always_ff @(posedge spi_clk)
  begin
    rs_s1_reg <= sys_rst;
    rs_s2_reg <= rs_s1_reg;
    ct_s1_reg <= ct_tgl_reg;
    ct_s2_reg <= ct_s1_reg;
    ct_s3_reg <= ct_s2_reg;
    cg_s1_reg <= cnt_tgl_reg;
    cg_s2_reg <= cg_s1_reg;
    cg_s3_reg <= cg_s2_reg;
    if (rs_s2_reg)
    begin
      ctl_reg <= sbp_txctl_t'({1'b0, LEN_RESET});
      mask_reg <= WORD_ZERO;
      ovr_reg <= 1'b0;
      cont_reg <= 1'b0;
      rcnt_reg <= LEN_RESET;
      irq_req_reg <= 1'b0;
    end
    else
    begin
      ctl_reg <= ctl_next;
      mask_reg <= mask_next;
      ovr_reg <= ovr_next;
      cont_reg <= cont_next;
      rcnt_reg <= rcnt_next;
      irq_req_reg <= irq_req_next;
    end
  end

  // system side: contention detect, count hand-off, level synchronisers
  always_comb
  begin
    act_s1_next = buf_act_reg;
    act_s2_next = act_s1_reg;
    cont_cond = act_s2_reg & (eng_rx_busy | eng_tx_busy);
    cont_d_next = cont_cond;
    ct_tgl_next = ct_tgl_reg ^ (cont_cond & ~cont_d_reg);
    cnt_hold_next = rx_count_load ? rx_count_in : cnt_hold_reg;
    cnt_tgl_next = cnt_tgl_reg ^ rx_count_load;
    irq_s1_next = irq_req_reg;
    irq_next = irq_s1_reg;
    ch_s1_next = ctl_reg.choice;
    ch_next = ch_s1_reg;
  end

  // system-domain registers, frozen while clk_en is low except that sys_rst still clears them
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      act_s1_reg <= 1'b0;
      act_s2_reg <= 1'b0;
      cont_d_reg <= 1'b0;
      ct_tgl_reg <= 1'b0;
      cnt_hold_reg <= LEN_RESET;
      cnt_tgl_reg <= 1'b0;
      irq_s1_reg <= 1'b0;
      irq_reg <= 1'b0;
      ch_s1_reg <= 1'b0;
      ch_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      act_s1_reg <= act_s1_next;
      act_s2_reg <= act_s2_next;
      cont_d_reg <= cont_d_next;
      ct_tgl_reg <= ct_tgl_next;
      cnt_hold_reg <= cnt_hold_next;
      cnt_tgl_reg <= cnt_tgl_next;
      irq_s1_reg <= irq_s1_next;
      irq_reg <= irq_next;
      ch_s1_reg <= ch_s1_next;
      ch_reg <= ch_next;
    end
  end

  assign irq = irq_reg;
  assign tx_buffer_choice = ch_reg;

endmodule : sbp_spi_burst

// file: tb/sbp_spi_burst_assertions.sv
// checker for the serial burst block, top-level ports only
// assumes mode-0 frames on spi_clk and sys_rst as in the design
`timescale 1ns/1ns
module sbp_spi_burst_assertions
  import sbp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic irq,
  input wire logic tx_buffer_choice
);
  logic [15:0] rise_reg;
  logic [7:0] hdr_reg;
  logic rd;
  logic known;
  logic in_w0;
  // rise count and header of the current frame
  always_ff @(posedge spi_clk or posedge cs_n)
    if (cs_n)
    begin
      rise_reg <= 16'h0000;
      hdr_reg <= 8'h00;
    end
    else
    begin
      rise_reg <= rise_reg + 16'h0001;
      if (rise_reg < 16'h0008)
        hdr_reg <= {hdr_reg[6:0], mosi};
    end
  // header decode and first-word window
  assign rd = hdr_reg[7];
  assign known = hdr_reg[5:0] inside {LOC_RX_BUF, LOC_TX_BUF, LOC_TX_CTL,
    LOC_IRQ_MASK, LOC_IRQ_STAT, LOC_RX_COUNT};
  assign in_w0 = rise_reg >= 16'h0008 && rise_reg <= 16'h0017;

  chk_miso_idle: assert property (
    @(posedge clk) disable iff (sys_rst) cs_n && $past(cs_n)
    |-> !miso && !miso_oe) else $error("miso driven outside frame");
  chk_oe_first: assert property (
    @(posedge spi_clk) disable iff (cs_n || sys_rst)
    rise_reg == 16'h0000 |-> !miso_oe) else $error("early miso_oe");
  chk_oe_held: assert property (
    @(posedge spi_clk) disable iff (cs_n || sys_rst)
    rise_reg != 16'h0000 |-> miso_oe) else $error("miso_oe dropped");
  chk_miso_fall: assert property (
    @(posedge clk) disable iff (sys_rst || cs_n)
    !($past(spi_clk) && !spi_clk) |-> $stable(miso))
    else $error("miso moved off a falling edge");
  chk_rx_dummy: assert property (
    @(posedge spi_clk) disable iff (cs_n || sys_rst)
    rd && hdr_reg[5:0] == LOC_RX_BUF && in_w0 |-> !miso)
    else $error("receive dummy word not zero");
  chk_unmapped_zero: assert property (
    @(posedge spi_clk) disable iff (cs_n || sys_rst)
    rd && !known && in_w0 |-> !miso) else $error("unmapped read not zero");
  chk_ctl_spare: assert property (
    @(posedge spi_clk) disable iff (cs_n || sys_rst)
    rd && hdr_reg[5:0] == LOC_TX_CTL && rise_reg >= 16'h0009
    && rise_reg <= 16'h0010 |-> !miso) else $error("ctl spare bit set");
  chk_rst_quiet: assert property (
    @(posedge clk) sys_rst && $past(sys_rst)
    |-> !irq && !tx_buffer_choice) else $error("outputs live in reset");
endmodule : sbp_spi_burst_assertions

bind sbp_spi_burst sbp_spi_burst_assertions i_sbp_spi_burst_assertions (
  .clk(clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n),
  .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .irq(irq),
  .tx_buffer_choice(tx_buffer_choice));

// file: tb/sbp_host_model.sv
// host model: mode-0 serial master, one transaction per frame call
// assumes a 12 ns link clock, idle low, stopped outside frames except while idle runs
`timescale 1ns/1ns
module sbp_host_model
(
  output logic spi_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // idle levels from time zero
  initial
  begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // link edges with no frame, used across reset
  task automatic idle(input int n);
    repeat (n)
    begin
      #6 spi_clk = 1'b1;
      #6 spi_clk = 1'b0;
    end
  endtask : idle
  // one framed transfer; device modelled as always awake
  task automatic frame(input logic [7:0] hdr, input int n,
    input logic [15:0] wq[$], output logic [15:0] rq[$]);
    logic [15:0] sh;
    rq = {};
    sh = 16'h0000;
    // deselect gap: cs_n stays high a while, clock stopped
    #12 cs_n = 1'b0;
    for (int i = 0; i < 8 + 16 * n; i++)
    begin
      if (i < 8)
        mosi = hdr[7 - i];
      else if ((i - 8) / 16 < wq.size())
        mosi = wq[(i - 8) / 16][15 - (i - 8) % 16];
      else
        mosi = ~mosi; // unused data line keeps moving
      #6 spi_clk = 1'b1;
      sh = {sh[14:0], miso};
      if (i >= 8 && (i - 8) % 16 == 15)
        rq.push_back(sh);
      #6 spi_clk = 1'b0;
    end
    #6 cs_n = 1'b1;
    mosi = ~mosi;
  endtask : frame
endmodule : sbp_host_model

// file: tb/tb.sv
// self-checking bench: host model frames, checker bound to the design
// assumes package, design, checker and host model compiled first
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("[FAIL] %0t got %h want %h", $time, a, b); \
    end \
  end
module tb
  import sbp_pkg::*;
;
  logic clk;
  logic sys_rst;
  logic eng_rx_busy;
  logic eng_tx_busy;
  logic rx_count_load;
  logic [LEN_W-1:0] rx_count_in;
  logic spi_clk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq;
  logic tx_buffer_choice;
  int bad_count;
  int checked;
  logic [15:0] rq[$];
  logic [15:0] wq[$];

  sbp_host_model i_sbp_host_model (.spi_clk(spi_clk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso));
  sbp_spi_burst i_sbp_spi_burst (.clk(clk), .clk_en(1'b1),
    .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(), .eng_rx_busy(eng_rx_busy),
    .eng_tx_busy(eng_tx_busy), .rx_count_in(rx_count_in),
    .rx_count_load(rx_count_load), .irq(irq),
    .tx_buffer_choice(tx_buffer_choice));

  // system clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [5:0] loc);
    i_sbp_host_model.frame({2'b00, loc}, wq.size(), wq, rq);
  endtask : wr

  task automatic rd(input logic [5:0] loc, input int n);
    wq = {};
    i_sbp_host_model.frame({2'b10, loc}, n, wq, rq);
  endtask : rd

  task automatic cmp(input logic [15:0] e[$]);
    `CHK(rq.size(), e.size())
    foreach (e[i])
      `CHK(rq[i], e[i])
  endtask : cmp

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic t_regs();
    logic [15:0] e[$];
    `CHK(tx_buffer_choice, 1'b0)
    wq = '{16'hffff, 16'h8055, 16'h1234, 16'h1000};
    wr(LOC_LAST);
    rd(LOC_LAST, 4);
    e = '{WORD_ZERO, 16'h8055, WORD_ZERO, 16'h1000};
    cmp(e);
    settle();
    `CHK(tx_buffer_choice, 1'b1)
    $display("regs done");
  endtask : t_regs

  task automatic t_txbuf();
    wq = '{16'ha001, 16'ha002, 16'ha003};
    wr(LOC_TX_BUF);
    wq = '{16'h0055};
    wr(LOC_TX_CTL);
    rd(LOC_TX_CTL, 1);
    cmp('{16'h0055});
    wq = '{16'hb001, 16'hb002};
    wr(LOC_TX_BUF);
    rd(LOC_TX_BUF, 2);
    cmp('{16'hb001, 16'hb002});
    settle();
    `CHK(tx_buffer_choice, 1'b0)
    wq = '{16'h8055};
    wr(LOC_TX_CTL);
    rd(LOC_TX_BUF, 3);
    cmp('{16'ha001, 16'ha002, 16'ha003});
    $display("txbuf done");
  endtask : t_txbuf

  task automatic t_rxbuf();
    logic [15:0] e[$];
    @(posedge clk);
    rx_count_in <= 7'h06;
    rx_count_load <= 1'b1;
    @(posedge clk);
    rx_count_load <= 1'b0;
    rd(LOC_RX_COUNT, 1);
    rd(LOC_RX_COUNT, 1);
    cmp('{16'h0006});
    wq = {};
    for (int i = 0; i < 65; i++)
      wq.push_back(16'hc000 + 16'(i));
    wr(LOC_RX_BUF);
    e = '{DUMMY_WORD};
    for (int i = 0; i < 64; i++)
      e.push_back(i == 2 ? 16'h02c0 : 16'hc000 + 16'(i));
    e.push_back(OVR_FILL);
    rd(LOC_RX_BUF, 66);
    cmp(e);
    settle();
    `CHK(irq, 1'b1)
    rd(LOC_IRQ_STAT, 2);
    cmp('{16'h4000, WORD_ZERO});
    settle();
    `CHK(irq, 1'b0)
    $display("rxbuf done");
  endtask : t_rxbuf

  task automatic t_cont();
    wq = '{16'h0800};
    wr(LOC_IRQ_MASK);
    rd(LOC_RX_BUF, 66);
    settle();
    `CHK(irq, 1'b0)
    fork
      rd(LOC_RX_BUF, 3);
      begin
        repeat (40) @(posedge clk);
        eng_rx_busy <= 1'b1;
      end
    join
    settle();
    `CHK(irq, 1'b1)
    rd(LOC_IRQ_STAT, 2);
    cmp('{16'h6000, WORD_ZERO});
    @(posedge clk);
    eng_rx_busy <= 1'b0;
    settle();
    `CHK(irq, 1'b0)
    $display("contention done");
  endtask : t_cont

  // transmit engine wants the buffer during a serial buffer read
  task automatic t_cont_tx();
    fork
      rd(LOC_TX_BUF, 3);
      begin
        repeat (40) @(posedge clk);
        eng_tx_busy <= 1'b1;
      end
    join
    settle();
    `CHK(irq, 1'b1)
    rd(LOC_IRQ_STAT, 2);
    cmp('{16'h2000, WORD_ZERO});
    @(posedge clk);
    eng_tx_busy <= 1'b0;
    settle();
    `CHK(irq, 1'b0)
    $display("tx contention done");
  endtask : t_cont_tx

  // reset with link edges, then the tests
  initial
  begin
    sys_rst = 1'b1;
    eng_rx_busy = 1'b0;
    eng_tx_busy = 1'b0;
    rx_count_in = LEN_RESET;
    rx_count_load = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    i_sbp_host_model.idle(5);
    @(posedge clk);
    sys_rst <= 1'b0;
    i_sbp_host_model.idle(4);
    t_regs();
    t_txbuf();
    t_rxbuf();
    t_cont();
    t_cont_tx();
    report_and_stop();
  end

  // watchdog well past the expected run length
  initial
  begin
    #200000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb
